/* File: hdl/tcs_pkg.sv */
// Constants, codes and carriers shared by the setup command block
package tcs_pkg;
  localparam int TCS_CLK_HZ = 20_000_000;
  localparam int TCS_OPND_TMO_MS = 100;
  localparam int TCS_ECHO_TMO_MS = 2000;
  localparam int TCS_WAKE_LOW_NS = 10_000;
  localparam int TCS_WAKE_CYC = (TCS_WAKE_LOW_NS * (TCS_CLK_HZ / 1_000_000)
                                 + 999) / 1000;
  localparam int TCS_OPND_TMO_CYC = (TCS_CLK_HZ / 1000) * TCS_OPND_TMO_MS;
  localparam int TCS_ECHO_TMO_CYC = (TCS_CLK_HZ / 1000) * TCS_ECHO_TMO_MS;
  localparam int TCS_RATE0_HZ = 46_875;
  localparam int TCS_RATE1_HZ = 93_750;
  localparam int TCS_RATE2_HZ = 375_000;
  localparam int TCS_RATE3_HZ = 1_500_000;
  localparam int TCS_HALF0 = TCS_CLK_HZ / (2 * TCS_RATE0_HZ);
  localparam int TCS_HALF1 = TCS_CLK_HZ / (2 * TCS_RATE1_HZ);
  localparam int TCS_HALF2 = TCS_CLK_HZ / (2 * TCS_RATE2_HZ);
  localparam int TCS_HALF3 = TCS_CLK_HZ / (2 * TCS_RATE3_HZ);
  localparam logic [7:0] TCS_CMD_PUT = 8'h70;
  localparam logic [7:0] TCS_CMD_GET = 8'h67;
  localparam logic [7:0] TCS_CMD_SLEEP = 8'h5a;
  localparam logic [7:0] TCS_CMD_RATE = 8'h11;
  localparam logic [7:0] TCS_CMD_SYNC = 8'h12;
  localparam logic [7:0] TCS_CMD_CLAMP = 8'h13;
  localparam logic [7:0] TCS_CMD_C1_HI = 8'h14;
  localparam logic [7:0] TCS_CMD_C1_LO = 8'h15;
  localparam logic [7:0] TCS_CMD_C2 = 8'h16;
  localparam logic [7:0] TCS_CMD_NOISE = 8'h17;
  localparam logic [7:0] TCS_NULL = 8'h00;
  localparam logic [7:0] TCS_RATE_MAX = 8'h03;
  localparam logic [7:0] TCS_BOOL_MAX = 8'h01;
  localparam logic [7:0] TCS_C1_HI_MAX = 8'h7f;
  localparam logic [1:0] TCS_RATE_RST = 2'h0;
  localparam logic TCS_SYNC_RST = 1'b0;
  localparam logic TCS_CLAMP_RST = 1'b0;
  localparam logic [6:0] TCS_C1_HI_RST = 7'h05;
  localparam logic [7:0] TCS_C1_LO_RST = 8'he9;
  localparam logic [7:0] TCS_C2_RST = 8'h08;
  localparam logic TCS_NOISE_RST = 1'b0;
  localparam logic TCS_DIR_GET = 1'b0;
  localparam logic TCS_DIR_PUT = 1'b1;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } tcs_byte_s;

  typedef enum logic [2:0] {
    TCS_IDLE = 3'b000,
    TCS_OPND = 3'b001,
    TCS_SLEEP_ECHO = 3'b010,
    TCS_SLEEP = 3'b011
  } tcs_state_e;
endpackage : tcs_pkg

/* File: hdl/tcs_link_slave.sv */
// Link byte shifter: samples the external link clock on mclk
`timescale 1ns/1ps
module tcs_link_slave
  import tcs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic link_sclk,
  input wire logic link_ss_n,
  input wire logic link_mosi,
  output logic link_miso_o,
  output logic link_miso_oe_n,
  output tcs_pkg::tcs_byte_s rx,
  input wire tcs_pkg::tcs_byte_s tx,
  output logic tx_pending,
  output logic tx_done
);
  logic [2:0] sclk_sync_reg;
  logic [1:0] ss_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] tx_sh_reg;
  logic [7:0] tx_hold_reg;
  wire sel = ~ss_sync_reg[1];
  wire rise = sel & sclk_sync_reg[1] & ~sclk_sync_reg[2];
  wire fall = sel & ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire last_bit = rise & (bit_cnt_reg == 3'h7);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sclk_sync_reg <= 3'h0;
      ss_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link_sclk};
      ss_sync_reg <= {ss_sync_reg[0], link_ss_n};
      mosi_sync_reg <= {mosi_sync_reg[0], link_mosi};
    end
  end

  // Rate is set by the host; sampling at 20 MHz covers up to 1.5 MHz
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx <= '0;
    end
    else
    begin
      rx.valid <= last_bit;
      if (!sel)
        bit_cnt_reg <= 3'h0;
      else if (rise)
      begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_sh_reg <= {rx_sh_reg[6:0], mosi_sync_reg[1]};
        if (bit_cnt_reg == 3'h7)
          rx.data <= {rx_sh_reg[6:0], mosi_sync_reg[1]};
      end
    end
  end

  // A load while a frame ends keeps the pending flag set
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_pending <= 1'b0;
      tx_hold_reg <= 8'h00;
      tx_sh_reg <= 8'h00;
      tx_done <= 1'b0;
    end
    else
    begin
      tx_done <= last_bit & tx_pending;
      if (tx.valid)
      begin
        tx_pending <= 1'b1;
        tx_hold_reg <= tx.data;
      end
      else if (last_bit)
        tx_pending <= 1'b0;
      if (!sel || last_bit)
        tx_sh_reg <= tx_pending ? tx_hold_reg : 8'h00;
      else if (fall)
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  assign link_miso_o = tx_sh_reg[7];
  assign link_miso_oe_n = ~sel;
endmodule : tcs_link_slave

/* File: hdl/tcs_setup_cmd.sv */
// Setup command interpreter: direction, sleep, link rate and settings
// What this block does
// - 0x70 selects write direction, 0x67 read; read is default.
// - Setting changes are taken only in write direction.
// - Sleep needs 0x5A then 0x00 within 100 ms, else abandoned.
// - Valid sleep echoes 0x5A before sleeping, and again after waking.
// - Sleep echo not sent within about two seconds forces full reset.
// - Wake input low over ten microseconds wakes, keeping prior settings but not direction.
// - Device always wakes in read direction.
// - Rate operand 0..3 picks 46.875k, 93.75k, 375k or 1.5 MHz master clock.
// - Slave mode accepts host clocking up to 1.5 MHz regardless.
// - New link rate applies only after power cycle or reset command.
// - Enabled scope sync drives a pulse around scoped key bursts.
// - Sync output rests low, high during each pulse.
// - Scope sync setting is volatile, off after power-down.
// - Clamp polarity operand 0 gives active-low, 1 active-high output.
// - Clamp polarity change applies after power cycle or reset command.
// - Constant one upper byte 0..127, default 5, weighs 256 counts.
// - Constant one lower byte 0..255, default 0xE9, joins upper byte.
// - Constant two 0..255, default 8, applies to all keys.
// - Boundary constants take effect after reset or full recalibration.
// - Noise sync operand enables external interference sync; default off.
// - Noise sync change applies after power cycle or reset command.
// - In read direction each boundary command returns its stored value.
`timescale 1ns/1ps
module tcs_setup_cmd
  import tcs_pkg::*;
#(
  parameter int OPND_TMO_CYC = tcs_pkg::TCS_OPND_TMO_CYC,
  parameter int ECHO_TMO_CYC = tcs_pkg::TCS_ECHO_TMO_CYC
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic link_sclk,
  input wire logic link_ss_n,
  input wire logic link_mosi,
  output logic link_miso_o,
  output logic link_miso_oe_n,
  input wire logic wake_input,
  input wire logic reset_cmd,
  input wire logic recal_all,
  input wire logic burst_active,
  input wire logic burst_in_scope,
  input wire logic clamp_request,
  output logic sync_out,
  output logic integrator_clamp_out,
  output logic master_sclk_tick,
  output logic [1:0] link_rate,
  output logic noise_sync_en,
  output logic [14:0] boundary_const_one,
  output logic [7:0] boundary_const_two,
  output logic put_dir,
  output logic sleeping,
  output logic full_reset_req
);
  import tcs_pkg::*;

  tcs_byte_s rx;
  tcs_byte_s tx;
  logic tx_pending;
  logic tx_done;
  tcs_state_e state_reg;
  tcs_state_e state_next;
  logic [7:0] cmd_reg;
  logic [31:0] tmo_reg;
  logic [7:0] wake_cnt_reg;
  logic [1:0] wake_sync_reg;
  logic dir_reg;
  logic [1:0] rate_reg;
  logic sync_en_reg;
  logic clamp_pol_reg;
  logic [6:0] c1_hi_reg;
  logic [7:0] c1_lo_reg;
  logic [7:0] c2_reg;
  logic noise_reg;
  logic clamp_act_reg;
  logic [7:0] div_reg;

  tcs_link_slave tcs_link_slave_inst (
    .mclk(mclk),
    .rst(rst),
    .link_sclk(link_sclk),
    .link_ss_n(link_ss_n),
    .link_mosi(link_mosi),
    .link_miso_o(link_miso_o),
    .link_miso_oe_n(link_miso_oe_n),
    .rx(rx),
    .tx(tx),
    .tx_pending(tx_pending),
    .tx_done(tx_done)
  );

  wire is_setting = (rx.data >= TCS_CMD_RATE) && (rx.data <= TCS_CMD_NOISE);
  wire idle_rx = (state_reg == TCS_IDLE) && rx.valid;
  wire opnd_rx = (state_reg == TCS_OPND) && rx.valid;
  wire tmo_hit = (tmo_reg == 32'(OPND_TMO_CYC));
  wire echo_tmo = (tmo_reg == 32'(ECHO_TMO_CYC));
  // Range check per command; failing operands store nothing
  wire opnd_ok =
    (cmd_reg == TCS_CMD_SLEEP) ? (rx.data == TCS_NULL) :
    (cmd_reg == TCS_CMD_RATE) ? (rx.data <= TCS_RATE_MAX) :
    (cmd_reg == TCS_CMD_C1_HI) ? (rx.data <= TCS_C1_HI_MAX) :
    (cmd_reg == TCS_CMD_C1_LO || cmd_reg == TCS_CMD_C2) ? 1'b1 :
    (rx.data <= TCS_BOOL_MAX);
  wire store = opnd_rx && opnd_ok;
  wire [7:0] get_val =
    (rx.data == TCS_CMD_RATE) ? {6'h00, rate_reg} :
    (rx.data == TCS_CMD_SYNC) ? {7'h00, sync_en_reg} :
    (rx.data == TCS_CMD_CLAMP) ? {7'h00, clamp_pol_reg} :
    (rx.data == TCS_CMD_C1_HI) ? {1'b0, c1_hi_reg} :
    (rx.data == TCS_CMD_C1_LO) ? c1_lo_reg :
    (rx.data == TCS_CMD_C2) ? c2_reg :
    {7'h00, noise_reg};
  wire wake_done = (state_reg == TCS_SLEEP) &&
                   (wake_cnt_reg > 8'(TCS_WAKE_CYC));
  wire dir_cmd = idle_rx &&
                 (rx.data == TCS_CMD_PUT || rx.data == TCS_CMD_GET);
  wire get_cmd = idle_rx && is_setting && (dir_reg == TCS_DIR_GET);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TCS_IDLE:
        // Read direction drops setting and sleep commands at once
        if (rx.valid && dir_reg == TCS_DIR_PUT &&
            (is_setting || rx.data == TCS_CMD_SLEEP))
          state_next = TCS_OPND;
      TCS_OPND:
        if (store && cmd_reg == TCS_CMD_SLEEP)
          state_next = TCS_SLEEP_ECHO;
        else if (rx.valid || tmo_hit)
          state_next = TCS_IDLE;
      TCS_SLEEP_ECHO:
        if (tx_done)
          state_next = TCS_SLEEP;
        else if (echo_tmo)
          state_next = TCS_IDLE;
      TCS_SLEEP:
        if (wake_done)
          state_next = TCS_IDLE;
      default:
        state_next = TCS_IDLE;
    endcase
  end

  // Echoes, read replies and the sleep bytes share one transmit slot
  always_comb
  begin
    tx.valid = 1'b0;
    tx.data = TCS_NULL;
    if (dir_cmd)
    begin
      tx.valid = 1'b1;
      tx.data = rx.data;
    end
    else if (get_cmd)
    begin
      tx.valid = 1'b1;
      tx.data = get_val;
    end
    else if (store)
    begin
      tx.valid = 1'b1;
      tx.data = cmd_reg;
    end
    else if (wake_done)
    begin
      tx.valid = 1'b1;
      tx.data = TCS_CMD_SLEEP;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= TCS_IDLE;
      cmd_reg <= TCS_NULL;
      tmo_reg <= 32'h0;
      full_reset_req <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      full_reset_req <= (state_reg == TCS_SLEEP_ECHO) && echo_tmo &&
                        !tx_done;
      if (idle_rx)
        cmd_reg <= rx.data;
      if (state_next != state_reg)
        tmo_reg <= 32'h0;
      else
        tmo_reg <= tmo_reg + 32'h1;
    end
  end

  // Wake input crosses into mclk before the low-time count
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wake_sync_reg <= 2'h3;
      wake_cnt_reg <= 8'h00;
    end
    else
    begin
      wake_sync_reg <= {wake_sync_reg[0], wake_input};
      if (state_reg != TCS_SLEEP || wake_sync_reg[1])
        wake_cnt_reg <= 8'h00;
      else if (!wake_done)
        wake_cnt_reg <= wake_cnt_reg + 8'h01;
    end
  end

  // Stored settings; reset gives the defaults, sync starts off
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dir_reg <= TCS_DIR_GET;
      rate_reg <= TCS_RATE_RST;
      sync_en_reg <= TCS_SYNC_RST;
      clamp_pol_reg <= TCS_CLAMP_RST;
      c1_hi_reg <= TCS_C1_HI_RST;
      c1_lo_reg <= TCS_C1_LO_RST;
      c2_reg <= TCS_C2_RST;
      noise_reg <= TCS_NOISE_RST;
    end
    else
    begin
      if (wake_done)
        dir_reg <= TCS_DIR_GET;
      else if (dir_cmd)
        dir_reg <= (rx.data == TCS_CMD_PUT);
      if (store)
      begin
        case (cmd_reg)
          TCS_CMD_RATE: rate_reg <= rx.data[1:0];
          TCS_CMD_SYNC: sync_en_reg <= rx.data[0];
          TCS_CMD_CLAMP: clamp_pol_reg <= rx.data[0];
          TCS_CMD_C1_HI: c1_hi_reg <= rx.data[6:0];
          TCS_CMD_C1_LO: c1_lo_reg <= rx.data;
          TCS_CMD_C2: c2_reg <= rx.data;
          TCS_CMD_NOISE: noise_reg <= rx.data[0];
          default: ;
        endcase
      end
    end
  end

  // Applied copies change only on reset_cmd, or recal_all for the boundary constants, so a write is deferred
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      link_rate <= TCS_RATE_RST;
      clamp_act_reg <= TCS_CLAMP_RST;
      noise_sync_en <= TCS_NOISE_RST;
      boundary_const_one <= {TCS_C1_HI_RST, TCS_C1_LO_RST};
      boundary_const_two <= TCS_C2_RST;
    end
    else
    begin
      if (reset_cmd)
      begin
        link_rate <= rate_reg;
        clamp_act_reg <= clamp_pol_reg;
        noise_sync_en <= noise_reg;
      end
      if (reset_cmd || recal_all)
        boundary_const_one <= {c1_hi_reg, c1_lo_reg};
      if (reset_cmd || recal_all)
        boundary_const_two <= c2_reg;
    end
  end

  // Master clock edge enable; truncated divide keeps rates at or above spec
  wire [7:0] half_cnt =
    (link_rate == 2'h0) ? 8'(TCS_HALF0 - 1) :
    (link_rate == 2'h1) ? 8'(TCS_HALF1 - 1) :
    (link_rate == 2'h2) ? 8'(TCS_HALF2 - 1) : 8'(TCS_HALF3 - 1);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      div_reg <= 8'h00;
      master_sclk_tick <= 1'b0;
      sync_out <= 1'b0;
      integrator_clamp_out <= 1'b0;
    end
    else
    begin
      master_sclk_tick <= (div_reg >= half_cnt);
      div_reg <= (div_reg >= half_cnt) ? 8'h00 : div_reg + 8'h01;
      sync_out <= sync_en_reg & burst_active &
                  burst_in_scope;
      integrator_clamp_out <= ~(clamp_request ^ clamp_act_reg);
    end
  end

  assign put_dir = dir_reg;
  assign sleeping = (state_reg == TCS_SLEEP);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_get_no_store: assert property (
    (rx.valid && state_reg == TCS_IDLE && dir_reg == TCS_DIR_GET)
      |=> state_reg == TCS_IDLE)
    else $error("read direction opened an operand phase");
  chk_opnd_timeout: assert property (
    (state_reg == TCS_OPND && tmo_hit && !rx.valid)
      |=> state_reg == TCS_IDLE)
    else $error("operand wait outlived its timeout");
  chk_sleep_echo: assert property (
    (opnd_rx && cmd_reg == TCS_CMD_SLEEP && rx.data == TCS_NULL)
      |-> tx.valid && tx.data == TCS_CMD_SLEEP ##1 state_reg == TCS_SLEEP_ECHO)
    else $error("sleep command not echoed");
  chk_echo_reset: assert property (
    (state_reg == TCS_SLEEP_ECHO && echo_tmo && !tx_done) |=> full_reset_req)
    else $error("missing full reset after echo timeout");
  chk_wake_time: assert property (
    $rose(sleeping) |-> !wake_done [*8])
    else $error("woke before low time elapsed");
  chk_wake_dir: assert property (
    wake_done |=> !put_dir && !sleeping)
    else $error("wake left write direction set");
  chk_rate_defer: assert property (
    !reset_cmd |=> $stable(link_rate))
    else $error("link rate applied without reset");
  chk_bad_operand: assert property (
    (opnd_rx && !opnd_ok) |=> $stable(rate_reg) && $stable(c1_hi_reg)
      && $stable(clamp_pol_reg) && $stable(noise_reg))
    else $error("out of range operand changed a setting");
  chk_sync_rest: assert property (
    !sync_en_reg ##1 !sync_en_reg |-> !sync_out)
    else $error("sync output high while disabled");
  chk_get_reply: assert property (
    (get_cmd && rx.data == TCS_CMD_C2) |-> tx.valid && tx.data == c2_reg)
    else $error("constant two read returned wrong value");
endmodule : tcs_setup_cmd

/* File: verification/tcs_host_model.sv */
// Host side model: mode 0 link master clocking whole bytes MSB first
`timescale 1ns/1ps
module tcs_host_model
(
  output logic link_sclk,
  output logic link_ss_n,
  output logic link_mosi,
  input wire logic link_miso
);
  localparam time HALF = 200ns;
  initial
  begin
    link_sclk = 1'b0;
    link_ss_n = 1'b1;
    link_mosi = 1'b1;
  end
  // Clock parked low between frames, 400 ns bit period
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    link_ss_n = 1'b0;
    link_mosi = tx[7];
    #HALF;
    for (int b = 7; b >= 0; b--)
    begin
      link_mosi = tx[b];
      #HALF;
      link_sclk = 1'b1;
      rx[b] = link_miso;
      #HALF;
      link_sclk = 1'b0;
    end
    #HALF;
    link_ss_n = 1'b1;
    // Released data line flips so a stale bit never looks valid
    link_mosi = ~tx[0];
    #(3 * HALF);
  endtask : xfer
  task automatic hold_select(input logic lvl);
    link_ss_n = lvl;
  endtask : hold_select
endmodule : tcs_host_model

/* File: verification/tcs_setup_cmd_bench.sv */
// Self-checking bench for the setup command interpreter
`timescale 1ns/1ps
module tcs_setup_cmd_bench;
  import tcs_pkg::*;
  // Short timeouts keep the run small
  localparam int OPND_CYC = 500;
  localparam int ECHO_CYC = 2000;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic wake_input = 1'b1;
  logic reset_cmd = 1'b0;
  logic recal_all = 1'b0;
  logic burst_active = 1'b0;
  logic burst_in_scope = 1'b0;
  logic clamp_request = 1'b0;
  logic link_sclk, link_ss_n, link_mosi, link_miso_o, link_miso_oe_n;
  wire logic link_miso;
  logic sync_out, integrator_clamp_out, master_sclk_tick, noise_sync_en;
  logic put_dir, sleeping, full_reset_req;
  logic [1:0] link_rate;
  logic [14:0] boundary_const_one;
  logic [7:0] boundary_const_two;
  logic [7:0] rx;
  int half_cyc[4] = '{TCS_HALF0, TCS_HALF1, TCS_HALF2, TCS_HALF3};
  int error_cnt = 0;
  int n_checks = 0;

  always #25 mclk = ~mclk;
  // Released line shows the inverse so a stale bit never looks valid
  assign link_miso = link_miso_oe_n ? ~link_miso_o : link_miso_o;

  tcs_setup_cmd #(.OPND_TMO_CYC(OPND_CYC), .ECHO_TMO_CYC(ECHO_CYC))
    tcs_setup_cmd_inst (.mclk(mclk), .rst(rst), .link_sclk(link_sclk),
    .link_ss_n(link_ss_n), .link_mosi(link_mosi),
    .link_miso_o(link_miso_o), .link_miso_oe_n(link_miso_oe_n),
    .wake_input(wake_input), .reset_cmd(reset_cmd), .recal_all(recal_all),
    .burst_active(burst_active), .burst_in_scope(burst_in_scope),
    .clamp_request(clamp_request), .sync_out(sync_out),
    .integrator_clamp_out(integrator_clamp_out),
    .master_sclk_tick(master_sclk_tick), .link_rate(link_rate),
    .noise_sync_en(noise_sync_en), .boundary_const_one(boundary_const_one),
    .boundary_const_two(boundary_const_two), .put_dir(put_dir),
    .sleeping(sleeping), .full_reset_req(full_reset_req));

  tcs_host_model tcs_host_model_inst (.link_sclk(link_sclk),
    .link_ss_n(link_ss_n), .link_mosi(link_mosi), .link_miso(link_miso));

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic bound(input int i, input int n, input string what);
    if (i >= n)
    begin
      error_cnt++;
      $display("unexpected timeout waiting for %s", what);
      finish_test();
    end
  endtask : bound
  task automatic send(input logic [7:0] b);
    tcs_host_model_inst.xfer(b, rx);
    step(1);
  endtask : send
  task automatic put2(input logic [7:0] c, input logic [7:0] o);
    send(c);
    send(o);
  endtask : put2
  task automatic apply(input logic recal);
    if (recal)
      recal_all = 1'b1;
    else
      reset_cmd = 1'b1;
    step(1);
    recal_all = 1'b0;
    reset_cmd = 1'b0;
    step(3);
  endtask : apply

  task automatic t_defaults();
    check("link_rate", link_rate, 0);
    check("put_dir", put_dir, TCS_DIR_GET);
    check("const_one", boundary_const_one, 15'h05e9);
    check("const_two", boundary_const_two, 8'h08);
    check("noise", noise_sync_en, 0);
    check("miso_released", link_miso_oe_n, 1);
    burst_active = 1'b1;
    burst_in_scope = 1'b1;
    step(3);
    check("sync_default", sync_out, 0);
    burst_active = 1'b0;
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_get_refuse();
    put2(TCS_CMD_RATE, 8'h02);
    check("get_rate", rx, 8'h00);
    send(TCS_CMD_C1_LO);
    send(TCS_NULL);
    check("get_c1_lo", rx, 8'he9);
    apply(1'b0);
    check("rate_kept", link_rate, 0);
    $display("test get_refuse done");
  endtask : t_get_refuse

  task automatic t_rate();
    int i;
    int n;
    send(TCS_CMD_PUT);
    check("put_dir", put_dir, TCS_DIR_PUT);
    for (int r = 3; r >= 0; r--)
    begin
      put2(TCS_CMD_RATE, 8'(r));
      send(TCS_NULL);
      check("rate_echo", rx, TCS_CMD_RATE);
      check("rate_deferred", link_rate, (r + 1) % 4);
      apply(1'b0);
      check("rate_applied", link_rate, r);
      for (i = 0; i < 500 && master_sclk_tick !== 1'b1; i++)
        step(1);
      bound(i, 500, "tick");
      step(1);
      for (n = 1; n < 500 && master_sclk_tick !== 1'b1; n++)
        step(1);
      check("tick_gap", n, half_cyc[r]);
    end
    put2(TCS_CMD_RATE, 8'h07);
    apply(1'b0);
    check("rate_range", link_rate, 0);
    $display("test rate done");
  endtask : t_rate

  task automatic t_clamp();
    clamp_request = 1'b1;
    step(2);
    check("clamp_low", integrator_clamp_out, 0);
    put2(TCS_CMD_CLAMP, 8'h01);
    send(TCS_NULL);
    check("clamp_echo", rx, TCS_CMD_CLAMP);
    check("clamp_deferred", integrator_clamp_out, 0);
    apply(1'b0);
    check("clamp_high", integrator_clamp_out, 1);
    clamp_request = 1'b0;
    step(2);
    check("clamp_idle", integrator_clamp_out, 0);
    $display("test clamp done");
  endtask : t_clamp

  task automatic t_bound();
    put2(TCS_CMD_C1_HI, 8'h7f);
    put2(TCS_CMD_C1_LO, 8'h12);
    put2(TCS_CMD_C2, 8'hff);
    put2(TCS_CMD_C1_HI, 8'h80);
    check("c1_deferred", boundary_const_one, 15'h05e9);
    apply(1'b1);
    check("c1_applied", boundary_const_one, 15'h7f12);
    check("c2_applied", boundary_const_two, 8'hff);
    send(TCS_CMD_GET);
    send(TCS_CMD_C1_HI);
    send(TCS_NULL);
    check("get_c1_hi", rx, 8'h7f);
    send(TCS_CMD_C2);
    send(TCS_NULL);
    check("get_c2", rx, 8'hff);
    send(TCS_CMD_PUT);
    $display("test bound done");
  endtask : t_bound

  task automatic t_noise_sync();
    put2(TCS_CMD_NOISE, 8'h01);
    check("noise_deferred", noise_sync_en, 0);
    apply(1'b0);
    check("noise_on", noise_sync_en, 1);
    put2(TCS_CMD_SYNC, 8'h01);
    burst_active = 1'b1;
    burst_in_scope = 1'b1;
    step(2);
    check("sync_pulse", sync_out, 1);
    burst_in_scope = 1'b0;
    step(2);
    check("sync_scope", sync_out, 0);
    burst_active = 1'b0;
    $display("test noise_sync done");
  endtask : t_noise_sync

  task automatic t_sleep();
    int i;
    put2(TCS_CMD_SLEEP, 8'h01);
    send(TCS_NULL);
    check("bad_operand", sleeping, 0);
    send(TCS_CMD_SLEEP);
    step(OPND_CYC + 100);
    send(TCS_NULL);
    send(TCS_NULL);
    check("late_operand", sleeping, 0);
    put2(TCS_CMD_SLEEP, TCS_NULL);
    send(TCS_NULL);
    check("sleep_echo", rx, TCS_CMD_SLEEP);
    step(2);
    check("asleep", sleeping, 1);
    wake_input = 1'b0;
    step(150);
    check("short_low", sleeping, 1);
    for (i = 0; i < 300 && sleeping !== 1'b0; i++)
      step(1);
    bound(i, 300, "wake");
    wake_input = 1'b1;
    check("wake_dir", put_dir, TCS_DIR_GET);
    check("kept_noise", noise_sync_en, 1);
    send(TCS_NULL);
    check("wake_echo", rx, TCS_CMD_SLEEP);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_echo_tmo();
    int i;
    send(TCS_CMD_PUT);
    put2(TCS_CMD_SLEEP, TCS_NULL);
    tcs_host_model_inst.hold_select(1'b0);
    for (i = 0; i < ECHO_CYC + 500 && full_reset_req !== 1'b1; i++)
      step(1);
    bound(i, ECHO_CYC + 500, "full reset");
    check("echo_wait", i > ECHO_CYC - 100, 1);
    check("miso_driven", link_miso_oe_n, 0);
    tcs_host_model_inst.hold_select(1'b1);
    $display("test echo_tmo done");
  endtask : t_echo_tmo

  initial
  begin
    step(20);
    rst = 1'b0;
    step(2);
    t_defaults();
    t_get_refuse();
    t_rate();
    t_clamp();
    t_bound();
    t_noise_sync();
    t_sleep();
    t_echo_tmo();
    finish_test();
  end
endmodule : tcs_setup_cmd_bench
